// file: cod_decode.sv
`timescale 1ns/1ps
`include "cod_consts.svh"
module cod_decode
	import cod_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        byte_valid,
	output      logic        byte_ready,
	input  wire cod_byte_t   byte_data,
	input  wire logic [15:0] pc_in,
	output      logic        instr_valid,
	output      cod_byte_t   instr_opcode,
	output      cod_byte_t   instr_operand1,
	output      cod_byte_t   instr_operand2,
	output      logic        instr_undefined,
	output      logic        alu_start,
	output      cod_alu_op_e alu_op,
	output      cod_pair_e   alu_pair,
	input  wire logic        alu_done,
	input  wire logic        alu_c,
	input  wire logic        alu_z,
	input  wire logic        alu_s,
	input  wire logic        alu_v,
	input  wire logic        alu_h,
	output      logic [3:0]  wreg_sel,
	input  wire cod_byte_t   wreg_rd_data,
	output      logic        wreg_wr_en,
	output      cod_byte_t   wreg_wr_data,
	output      logic        pc_load,
	output      logic [15:0] pc_value,
	output      logic        pop_req,
	input  wire logic        pop_ack,
	input  wire cod_byte_t   pop_data,
	input  wire logic        flags_wr_en,
	input  wire cod_byte_t   flags_wr_data,
	output      cod_byte_t   flags,
	output      logic        interrupt_enable,
	output      cod_byte_t   working_register_pointer
);

	cod_state_e  state_q;
	cod_byte_t   opc_q;
	cod_byte_t   op1_q;
	cod_byte_t   op2_q;
	logic [1:0]  len_q;
	logic        byte_take;
	logic        is_alu;
	logic        is_alu_q;
	cod_alu_op_e alu_op_q;
	cod_byte_t   dec_val;
	cod_byte_t   pc_hi_q;
	logic        cond_taken;

	cod_cond_if cif ();

	cod_cond_eval u_cond (
		.cif (cif)
	);

	// Instruction length in bytes
	function automatic logic [1:0] instr_len(input cod_byte_t op);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		if (lo == `COD_LO_ONEBYTE || lo == `COD_LO_INC)
			instr_len = 2'd1;
		else if (lo == `COD_LO_JP || op == `COD_OP_CALL_DA || op == 8'hC7 || op == 8'hD7 || op == 8'hF5)
			instr_len = 2'd3;
		else if (lo >= 4'h4 && lo <= 4'h7 && (hi <= 4'h7 || hi >= 4'hA))
			instr_len = 2'd3;
		else
			instr_len = 2'd2;
	endfunction

	// Arithmetic and logic group membership
	function automatic logic alu_group(input cod_byte_t op);
		alu_group = (op[3:0] >= 4'h2 && op[3:0] <= 4'h7) &&
			(op[7:4] <= 4'h7 || op[7:4] == 4'hA || op[7:4] == 4'hB);
	endfunction

	// Blank map positions
	function automatic logic undefined_op(input cod_byte_t op);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		case (hi)
			4'h8, 4'h9: undefined_op = (lo >= 4'h2 && lo <= 4'h7);
			4'hC:       undefined_op = (lo >= 4'h4 && lo <= 4'h6);
			4'hD:       undefined_op = (lo == 4'h2 || lo == 4'h3 || lo == 4'h5);
			4'hE:       undefined_op = (lo == 4'h2);
			4'hF:       undefined_op = (lo == 4'h2 || lo == 4'h4 || lo == 4'h6 || lo == 4'h7);
			4'h0, 4'h1, 4'h2: undefined_op = (lo == `COD_LO_ONEBYTE);
			default:    undefined_op = 1'b0;
		endcase
	endfunction

	assign is_alu = alu_group(opc_q);
	assign byte_take = byte_valid && byte_ready;
	assign cif.cond_code = opc_q[7:4];
	assign cif.flags = flags;
	assign cond_taken = cif.taken;
	assign wreg_sel = opc_q[7:4];
	assign dec_val = wreg_rd_data - 8'h01;
	assign alu_op = alu_op_q;

	always_comb
	begin
		byte_ready = (state_q == COD_S_OPC) || (state_q == COD_S_OP1) || (state_q == COD_S_OP2);
		pop_req = (state_q == COD_S_POP_FLAGS) || (state_q == COD_S_POP_PC_HI) || (state_q == COD_S_POP_PC_LO);
	end

	// Fetch and sequence
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= COD_S_OPC;
			opc_q <= 8'h00;
			op1_q <= 8'h00;
			op2_q <= 8'h00;
			len_q <= 2'd1;
			pc_hi_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				COD_S_OPC:
					if (byte_take)
					begin
						opc_q <= byte_data;
						len_q <= instr_len(byte_data);
						state_q <= (instr_len(byte_data) == 2'd1) ? COD_S_EXEC : COD_S_OP1;
					end
				COD_S_OP1:
					if (byte_take)
					begin
						op1_q <= byte_data;
						state_q <= (len_q == 2'd3) ? COD_S_OP2 : COD_S_EXEC;
					end
				COD_S_OP2:
					if (byte_take)
					begin
						op2_q <= byte_data;
						state_q <= COD_S_EXEC;
					end
				COD_S_EXEC:
					if (opc_q == `COD_OP_INTERRUPT_RETURN_OP)
						state_q <= COD_S_POP_FLAGS;
					else if (is_alu)
						state_q <= COD_S_ALU_WAIT;
					else
						state_q <= COD_S_OPC;
				COD_S_ALU_WAIT:
					if (alu_done)
						state_q <= COD_S_OPC;
				COD_S_POP_FLAGS:
					if (pop_ack)
						state_q <= COD_S_POP_PC_HI;
				COD_S_POP_PC_HI:
					if (pop_ack)
					begin
						pc_hi_q <= pop_data;
						state_q <= COD_S_POP_PC_LO;
					end
				COD_S_POP_PC_LO:
					if (pop_ack)
						state_q <= COD_S_OPC;
				default:
					state_q <= COD_S_OPC;
			endcase
		end
	end

	// Decoded instruction presentation
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_valid <= 1'b0;
			instr_opcode <= 8'h00;
			instr_operand1 <= 8'h00;
			instr_operand2 <= 8'h00;
			instr_undefined <= 1'b0;
			alu_start <= 1'b0;
			alu_op_q <= COD_ALU_SUM;
			alu_pair <= COD_PAIR_WR_WR;
			is_alu_q <= 1'b0;
		end
		else
		begin
			instr_valid <= (state_q == COD_S_EXEC);
			instr_undefined <= (state_q == COD_S_EXEC) && undefined_op(opc_q);
			alu_start <= (state_q == COD_S_EXEC) && is_alu;
			if (state_q == COD_S_EXEC)
			begin
				instr_opcode <= opc_q;
				instr_operand1 <= op1_q;
				instr_operand2 <= op2_q;
				is_alu_q <= is_alu;
				if (is_alu)
				begin
					alu_op_q <= cod_alu_op_e'(opc_q[7:4]);
					alu_pair <= cod_pair_e'(opc_q[3:0]);
				end
			end
		end
	end

	// Branches, decrement loop and return address
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
			wreg_wr_en <= 1'b0;
			wreg_wr_data <= 8'h00;
		end
		else
		begin
			pc_load <= 1'b0;
			wreg_wr_en <= 1'b0;
			if (state_q == COD_S_EXEC)
			begin
				case (opc_q[3:0])
					`COD_LO_DECREMENT_BRANCH_NONZERO_OP:
					begin
						wreg_wr_en <= 1'b1;
						wreg_wr_data <= dec_val;
						if (dec_val != 8'h00)
						begin
							pc_load <= 1'b1;
							pc_value <= pc_in + {{8{op1_q[7]}}, op1_q};
						end
					end
					`COD_LO_JR:
						if (cond_taken)
						begin
							pc_load <= 1'b1;
							pc_value <= pc_in + {{8{op1_q[7]}}, op1_q};
						end
					`COD_LO_JP:
						if (cond_taken)
						begin
							pc_load <= 1'b1;
							pc_value <= {op1_q, op2_q};
						end
					default:
						pc_load <= 1'b0;
				endcase
			end
			else if (state_q == COD_S_POP_PC_LO && pop_ack)
			begin
				pc_load <= 1'b1;
				pc_value <= {pc_hi_q, pop_data};
			end
		end
	end

	// Interrupt enable and register pointer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			interrupt_enable <= `COD_IEN_RST;
			working_register_pointer <= `COD_RP_RST;
		end
		else if (state_q == COD_S_EXEC)
		begin
			if (opc_q == `COD_OP_DI)
				interrupt_enable <= 1'b0;
			else if (opc_q == `COD_OP_EI)
				interrupt_enable <= 1'b1;
			if (opc_q == `COD_OP_SRP)
				working_register_pointer <= op1_q;
		end
		else if (state_q == COD_S_POP_PC_LO && pop_ack)
			interrupt_enable <= 1'b1;
	end

	// Flag register; bits 1:0 are unused and hold zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags <= `COD_FLAGS_RST;
		else if (state_q == COD_S_POP_FLAGS && pop_ack)
			flags <= {pop_data[7:2], 2'b00};
		else if (state_q == COD_S_ALU_WAIT && alu_done && is_alu_q)
		begin
			flags[`COD_FLAG_Z] <= alu_z;
			flags[`COD_FLAG_S] <= alu_s;
			case (alu_op_q)
				COD_ALU_SUM, COD_ALU_SUM_C:
				begin
					flags[`COD_FLAG_C] <= alu_c;
					flags[`COD_FLAG_V] <= alu_v;
					flags[`COD_FLAG_H] <= alu_h;
					flags[`COD_FLAG_D] <= 1'b0;
				end
				COD_ALU_DIFF, COD_ALU_DIFF_B:
				begin
					flags[`COD_FLAG_C] <= alu_c;
					flags[`COD_FLAG_V] <= alu_v;
					flags[`COD_FLAG_H] <= alu_h;
					flags[`COD_FLAG_D] <= 1'b1;
				end
				COD_ALU_COMPARE:
				begin
					flags[`COD_FLAG_C] <= alu_c;
					flags[`COD_FLAG_V] <= alu_v;
				end
				default:
					flags[`COD_FLAG_V] <= 1'b0;
			endcase
		end
		else if (state_q == COD_S_EXEC && opc_q == `COD_OP_RCF)
			flags[`COD_FLAG_C] <= 1'b0;
		else if (state_q == COD_S_EXEC && opc_q == `COD_OP_SCF)
			flags[`COD_FLAG_C] <= 1'b1;
		else if (state_q == COD_S_EXEC && opc_q == `COD_OP_CCF)
			flags[`COD_FLAG_C] <= ~flags[`COD_FLAG_C];
		else if (flags_wr_en)
			flags <= {flags_wr_data[7:2], 2'b00};
	end

endmodule // cod_decode

// file: cod_consts.svh
`ifndef COD_CONSTS_SVH
`define COD_CONSTS_SVH

// Register addresses
`define COD_FLAGS_ADDR      8'hFC
`define COD_MASK_ADDR       8'hFB
`define COD_RP_ADDR         8'hFD

// Bit positions inside the flag register and the mask register
`define COD_FLAG_C          7
`define COD_FLAG_Z          6
`define COD_FLAG_S          5
`define COD_FLAG_V          4
`define COD_FLAG_D          3
`define COD_FLAG_H          2
`define COD_MASK_ENABLE_BIT 7

// Reset values
`define COD_FLAGS_RST       8'h00
`define COD_RP_RST          8'h00
`define COD_IEN_RST         1'b0

// Whole opcodes
`define COD_OP_DI           8'h8F
`define COD_OP_EI           8'h9F
`define COD_OP_INTERRUPT_RETURN_OP         8'hBF
`define COD_OP_RCF          8'hCF
`define COD_OP_SCF          8'hDF
`define COD_OP_CCF          8'hEF
`define COD_OP_SRP          8'h31
`define COD_OP_CALL_DA      8'hD6

// Lower nibbles with a fixed meaning across rows
`define COD_LO_DECREMENT_BRANCH_NONZERO_OP         4'hA
`define COD_LO_JR           4'hB
`define COD_LO_JP           4'hD
`define COD_LO_INC          4'hE
`define COD_LO_ONEBYTE      4'hF

// Condition codes
`define COD_CC_NEVER        4'h0
`define COD_CC_LT           4'h1
`define COD_CC_LE           4'h2
`define COD_CC_ULE          4'h3
`define COD_CC_OV           4'h4
`define COD_CC_MI           4'h5
`define COD_CC_Z            4'h6
`define COD_CC_C            4'h7
`define COD_CC_ALWAYS       4'h8
`define COD_CC_GE           4'h9
`define COD_CC_GT           4'hA
`define COD_CC_UGT          4'hB
`define COD_CC_NOV          4'hC
`define COD_CC_PL           4'hD
`define COD_CC_NZ           4'hE
`define COD_CC_NC           4'hF

`endif

// file: cod_pkg.sv
package cod_pkg;

	typedef enum logic [3:0] {
		COD_ALU_SUM      = 4'h0,
		COD_ALU_SUM_C    = 4'h1,
		COD_ALU_DIFF     = 4'h2,
		COD_ALU_DIFF_B   = 4'h3,
		COD_ALU_OR       = 4'h4,
		COD_ALU_AND      = 4'h5,
		COD_ALU_CTEST    = 4'h6,
		COD_ALU_TEST     = 4'h7,
		COD_ALU_COMPARE  = 4'hA,
		COD_ALU_XOR      = 4'hB
	} cod_alu_op_e;

	typedef enum logic [3:0] {
		COD_PAIR_WR_WR   = 4'h2,
		COD_PAIR_WR_IWR  = 4'h3,
		COD_PAIR_R_R     = 4'h4,
		COD_PAIR_R_IR    = 4'h5,
		COD_PAIR_R_IM    = 4'h6,
		COD_PAIR_IR_IM   = 4'h7
	} cod_pair_e;

	typedef enum logic [3:0] {
		COD_S_OPC        = 4'b0000,
		COD_S_OP1        = 4'b0001,
		COD_S_OP2        = 4'b0010,
		COD_S_EXEC       = 4'b0011,
		COD_S_ALU_WAIT   = 4'b0100,
		COD_S_POP_FLAGS  = 4'b0101,
		COD_S_POP_PC_HI  = 4'b0110,
		COD_S_POP_PC_LO  = 4'b0111
	} cod_state_e;

	typedef logic [7:0] cod_byte_t;

endpackage

// file: cod_cond_if.sv
`timescale 1ns/1ps
interface cod_cond_if;
	logic [3:0] cond_code;
	logic [7:0] flags;
	logic       taken;

	modport decoder (output cond_code, output flags, input taken);
	modport evaluator (input cond_code, input flags, output taken);
endinterface

// file: cod_cond_eval.sv
`timescale 1ns/1ps
`include "cod_consts.svh"
module cod_cond_eval
	import cod_pkg::*;
(
	cod_cond_if.evaluator cif
);

	function automatic logic eval_cond(input logic [3:0] cc, input logic [7:0] f);
		logic c;
		logic z;
		logic sv;
		c = f[`COD_FLAG_C];
		z = f[`COD_FLAG_Z];
		sv = f[`COD_FLAG_S] ^ f[`COD_FLAG_V];
		case (cc)
			`COD_CC_ALWAYS: eval_cond = 1'b1;
			`COD_CC_NEVER:  eval_cond = 1'b0;
			`COD_CC_C:      eval_cond = c;
			`COD_CC_NC:     eval_cond = ~c;
			`COD_CC_Z:      eval_cond = z;
			`COD_CC_NZ:     eval_cond = ~z;
			`COD_CC_PL:     eval_cond = ~f[`COD_FLAG_S];
			`COD_CC_MI:     eval_cond = f[`COD_FLAG_S];
			`COD_CC_OV:     eval_cond = f[`COD_FLAG_V];
			`COD_CC_NOV:    eval_cond = ~f[`COD_FLAG_V];
			`COD_CC_GE:     eval_cond = ~sv;
			`COD_CC_LT:     eval_cond = sv;
			`COD_CC_LE:     eval_cond = z | sv;
			`COD_CC_GT:     eval_cond = ~(z | sv);
			`COD_CC_UGT:    eval_cond = ~c & ~z;
			`COD_CC_ULE:    eval_cond = c | z;
			default:        eval_cond = 1'b0;
		endcase
	endfunction

	assign cif.taken = eval_cond(cif.cond_code, cif.flags);

endmodule // cod_cond_eval

// file: cod_decode_asserts.sv
`timescale 1ns/1ps
module cod_decode_asserts
	import cod_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire cod_byte_t   instr_opcode,
	input wire cod_byte_t   instr_operand1,
	input wire logic        instr_undefined,
	input wire logic        alu_start,
	input wire cod_alu_op_e alu_op,
	input wire cod_pair_e   alu_pair,
	input wire logic        alu_done,
	input wire cod_byte_t   wreg_rd_data,
	input wire logic        wreg_wr_en,
	input wire cod_byte_t   wreg_wr_data,
	input wire logic [15:0] pc_in,
	input wire logic        pc_load,
	input wire logic [15:0] pc_value,
	input wire logic        pop_req,
	input wire cod_byte_t   flags,
	input wire logic        interrupt_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence ret_load;
		pc_load && interrupt_enable ##1 !pc_load;
	endsequence

	alu_fields_a: assert property (alu_start |->
		instr_valid && alu_op == instr_opcode[7:4] && alu_pair == instr_opcode[3:0]) else $error("alu fields wrong");
	decrement_branch_nonzero_op_data_a: assert property (wreg_wr_en |->
		wreg_wr_data == $past(wreg_rd_data) - 8'h01) else $error("loop count not decremented");
	decrement_branch_nonzero_op_branch_a: assert property (wreg_wr_en |->
		pc_load == (wreg_wr_data != 8'h00)) else $error("loop branch wrong");
	ien_ops_a: assert property (instr_valid && instr_opcode inside {8'h8F, 8'h9F} |->
		interrupt_enable == instr_opcode[4]) else $error("interrupt enable op wrong");
	interrupt_return_op_end_a: assert property ($fell(pop_req) |-> ret_load) else $error("return end wrong");
	carry_set_a: assert property (instr_valid && instr_opcode inside {8'hCF, 8'hDF} |->
		flags[7] == instr_opcode[4]) else $error("carry set or clear wrong");
	carry_cpl_a: assert property (instr_valid && instr_opcode == 8'hEF |->
		flags[7] != $past(flags[7])) else $error("carry not inverted");
	logic_v_a: assert property (alu_done &&
		alu_op inside {COD_ALU_OR, COD_ALU_AND, COD_ALU_CTEST, COD_ALU_TEST, COD_ALU_XOR} |-> ##[1:2] !flags[4])
		else $error("logic op kept overflow");
	arith_d_a: assert property (alu_done &&
		alu_op inside {COD_ALU_SUM, COD_ALU_SUM_C, COD_ALU_DIFF, COD_ALU_DIFF_B} |-> ##[1:2] flags[3] == alu_op[1])
		else $error("decimal flag wrong");
	jr_target_a: assert property (instr_valid && pc_load && instr_opcode[3:0] == 4'hB |->
		pc_value == $past(pc_in) + {{8{instr_operand1[7]}}, instr_operand1}) else $error("relative target wrong");
	undef_a: assert property (instr_undefined |->
		instr_valid && !alu_start && !pc_load && !wreg_wr_en) else $error("blank op acted");
endmodule // cod_decode_asserts

bind cod_decode cod_decode_asserts cod_decode_asserts_i (.*);

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module tb_top
	import cod_pkg::*;
;
	logic        clk, rst_n, byte_valid, alu_done, alu_c, alu_z, alu_s, alu_v, alu_h, pop_ack, flags_wr_en;
	logic        byte_ready, instr_valid, instr_undefined, alu_start, wreg_wr_en, pc_load, pop_req, interrupt_enable;
	cod_byte_t   byte_data, pop_data, flags_wr_data, wreg_rd_data, instr_opcode, instr_operand1, instr_operand2;
	cod_byte_t   wreg_wr_data, flags, working_register_pointer;
	cod_alu_op_e alu_op;
	cod_pair_e   alu_pair;
	logic [3:0]  wreg_sel, p;
	logic [15:0] pc_in, pc_value;
	cod_byte_t   regs [16];
	int          mismatches, checks_done;
	// Row: flags, condition code, taken
	logic [15:0] rows [30] = '{16'h0000, 16'h0081, 16'h8071, 16'h0070, 16'h00F1, 16'h80F0, 16'h4061, 16'h40E0,
		16'h20D0, 16'h2051, 16'h1041, 16'h10C0, 16'h3091, 16'h2090, 16'h2011, 16'h3010, 16'h30A1, 16'h40A0,
		16'h10A0, 16'h1021, 16'h0020, 16'h4021, 16'h00B1, 16'h40B0, 16'h80B0, 16'h8031, 16'h0030, 16'h00E1,
		16'h00D1, 16'h00C1};
	logic [3:0]  ops [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB};
	cod_byte_t   efl [10] = '{8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'h4C, 8'h4C, 8'h4C, 8'h4C, 8'hDC, 8'h4C};
	// Row: opcode, flags after, interrupt enable after
	logic [19:0] cops [6] = '{20'h9F7C1, 20'hDFFC1, 20'hEF7C1, 20'hEFFC1, 20'hCF7C1, 20'h8F7C0};
	cod_byte_t   pv [3] = '{8'h5B, 8'hAB, 8'hCD};

	assign wreg_rd_data = regs[wreg_sel];

	cod_decode cod_decode_i (.*);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic send(input int n, input cod_byte_t b0, input cod_byte_t b1 = 8'h00, input cod_byte_t b2 = 8'h00);
		for (int i = 0; i < n; i++)
		begin
			repeat (100) if (byte_ready !== 1'b1) @(negedge clk);
			byte_data = (i == 0) ? b0 : (i == 1) ? b1 : b2;
			byte_valid = 1'b1;
			@(negedge clk);
		end
		byte_valid = 1'b0;
		@(negedge clk);
	endtask

	task automatic wflags(input cod_byte_t v);
		flags_wr_data = v;
		flags_wr_en = 1'b1;
		@(negedge clk);
		flags_wr_en = 1'b0;
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		{rst_n, byte_valid, alu_done, alu_c, alu_z, alu_s, alu_v, alu_h, pop_ack, flags_wr_en} = '0;
		{byte_data, pop_data, flags_wr_data} = '0;
		pc_in = 16'h1234;
		foreach (regs[i]) regs[i] = 8'h33;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		`CHK("flags", 8'h00, flags)
		`CHK("ien", 1'b0, interrupt_enable)
		`CHK("ready", 1'b1, byte_ready)
		wflags(8'hFF);
		`CHK("flag bits", 8'hFC, flags)
		$display("test reset done");
		foreach (rows[i])
		begin
			wflags(rows[i][15:8]);
			send(2, {rows[i][7:4], 4'hB}, 8'hF0);
			`CHK("taken", rows[i][0], pc_load)
			if (rows[i][0]) `CHK("target", 16'h1224, pc_value)
		end
		$display("test conditions done");
		{alu_c, alu_z, alu_v} = 3'b111;
		foreach (ops[i])
		begin
			p = 4'(2 + i % 6);
			alu_h = i[0];
			wflags(8'h2C);
			send((p > 4'h3) ? 3 : 2, {ops[i], p}, 8'h12, 8'h34);
			`CHK("alu op", ops[i], alu_op)
			`CHK("alu pair", p, alu_pair)
			`CHK("alu start", 1'b1, alu_start)
			`CHK("valid", 1'b1, instr_valid)
			`CHK("operand one", 8'h12, instr_operand1)
			if (p > 4'h3) `CHK("operand two", 8'h34, instr_operand2)
			@(negedge clk);
			`CHK("refused", 1'b0, byte_ready)
			alu_done = 1'b1;
			@(negedge clk);
			alu_done = 1'b0;
			@(negedge clk);
			`CHK("alu flags", efl[i], flags)
		end
		$display("test alu done");
		wflags(8'h7C);
		foreach (cops[i])
		begin
			send(1, cops[i][19:12]);
			`CHK("op flags", cops[i][11:4], flags)
			`CHK("op ien", cops[i][0], interrupt_enable)
		end
		$display("test one byte ops done");
		for (int k = 2; k > 0; k--)
		begin
			regs[5] = 8'(k);
			send(2, 8'h5A, 8'h7F);
			`CHK("loop write", 1'b1, wreg_wr_en)
			`CHK("loop data", 8'(k - 1), wreg_wr_data)
			`CHK("loop branch", k == 2, pc_load)
			if (k == 2) `CHK("loop target", 16'h12B3, pc_value)
		end
		$display("test loop done");
		send(3, 8'h8D, 8'h56, 8'h78);
		`CHK("jump taken", 1'b1, pc_load)
		`CHK("jump target", 16'h5678, pc_value)
		`CHK("jump op two", 8'h78, instr_operand2)
		send(3, 8'h0D, 8'h9A, 8'hBC);
		`CHK("jump never", 1'b0, pc_load)
		send(2, 8'h31, 8'hC0);
		`CHK("pointer", 8'hC0, working_register_pointer)
		$display("test jump done");
		send(1, 8'hBF);
		foreach (pv[i])
		begin
			@(negedge clk);
			repeat (20) if (pop_req !== 1'b1) @(negedge clk);
			`CHK("pop req", 1'b1, pop_req)
			pop_data = pv[i];
			pop_ack = 1'b1;
			@(negedge clk);
			pop_ack = 1'b0;
		end
		`CHK("ret load", 1'b1, pc_load)
		`CHK("ret pc", 16'hABCD, pc_value)
		`CHK("ret ien", 1'b1, interrupt_enable)
		`CHK("ret flags", 8'h58, flags)
		$display("test return done");
		send(1, 8'h0F);
		`CHK("blank", 1'b1, instr_undefined)
		send(2, 8'hD2);
		`CHK("blank two", 1'b1, instr_undefined)
		`CHK("blank flags", 8'h58, flags)
		$display("test blank done");
		// Reset in mid-run must clear state as at power-up
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("rst ien", 1'b0, interrupt_enable)
		`CHK("rst flags", 8'h00, flags)
		`CHK("rst ready", 1'b1, byte_ready)
		`CHK("rst pop", 1'b0, pop_req)
		rst_n = 1'b1;
		send(1, 8'h9F);
		`CHK("ien after reset", 1'b1, interrupt_enable)
		$display("test second reset done");
		give_verdict;
	end

	// Whole run needs under 1000 cycles; generous margin
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		give_verdict;
	end
endmodule // tb_top
